// file: logic/bridge_config_id_and_command.sv
// identification and command registers of the virtual bridge function
`timescale 1ns/1ps
`default_nettype none
`include "bridge_cfg_defines.svh"

module bridge_config_id_and_command #(
    // arbitrary identity values, not of any real part
    parameter logic [15:0] MAKER_CODE = 16'h1A2B,
    parameter logic [15:0] PART_CODE = 16'h3C4D
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cfg_valid,
    input wire bridge_cfg_pkg::cfg_req_t cfg_req,
    output logic cfg_ack_q,
    output logic [31:0] cfg_rdata_q,
    input wire logic access_valid,
    input wire bridge_cfg_pkg::access_t access,
    output logic mem_claim_q,
    output logic io_claim_q,
    input wire logic [15:0] memory_window_base,
    input wire logic [15:0] memory_window_limit,
    input wire logic [15:0] prefetch_window_base,
    input wire logic [15:0] prefetch_window_limit,
    input wire logic [7:0] io_window_base,
    input wire logic [7:0] io_window_limit,
    input wire logic [3:0] bridge_error_events,
    input wire logic [3:0] bridge_control_error_enables,
    input wire logic host_error_event,
    input wire logic host_system_error_enable,
    output logic serr_msg_valid_q,
    output bridge_cfg_pkg::serr_msg_t serr_msg_q,
    input wire logic serr_msg_ready
);

    logic [15:0] bridge_command_q;
    logic [15:0] bridge_command_d;
    logic system_error_signaled_flag_q;
    logic bridge_sent;
    logic [7:0] dword_offset;
    logic hit_id;
    logic hit_cmd_sts;
    logic cmd_write;
    logic [15:0] cmd_lane_mask;
    logic sts_clear_sse;
    logic [15:0] bridge_status;
    logic [31:0] read_value;
    logic system_error_message_enable;
    logic memory_space_enable;
    logic io_space_enable;
    logic bus_master_enable;

    // address decode of the configuration cycle
    assign dword_offset = cfg_req.offset & `CFG_OFF_DWORD_MASK;
    assign hit_id = (dword_offset == `CFG_OFF_ID);
    assign hit_cmd_sts = (dword_offset == `CFG_OFF_CMD_STS);
    assign cmd_write = cfg_valid && cfg_req.write && hit_cmd_sts;

    // byte lanes 0 and 1 reach the command word
    assign cmd_lane_mask = {{8{cfg_req.byte_en[1]}},
        {8{cfg_req.byte_en[0]}}};

    // lane 3 holds the upper status byte
    assign sts_clear_sse = cmd_write && cfg_req.byte_en[3]
        && cfg_req.wdata[16 + `STS_SERR_SIGNALED_BIT];

    // only enable bits and bus master are stored
    always_comb begin
        bridge_command_d = bridge_command_q;
        if (cmd_write) begin
            bridge_command_d = (bridge_command_q & ~cmd_lane_mask)
                | (cfg_req.wdata[15:0] & cmd_lane_mask);
        end
        // bits 15:9, 7:3 never hold a value
        bridge_command_d = bridge_command_d
            & `CMD_WRITABLE_MASK;
    end

    // command register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bridge_command_q <= `CMD_RESET_VALUE;
        end else begin
            bridge_command_q <= bridge_command_d;
        end
    end

    // named views of the live command bits
    assign system_error_message_enable =
        bridge_command_q[`CMD_SERR_ENABLE_BIT];
    assign memory_space_enable =
        bridge_command_q[`CMD_MEMORY_SPACE_BIT];
    assign io_space_enable =
        bridge_command_q[`CMD_IO_SPACE_BIT];
    // readback only, steers nothing
    assign bus_master_enable =
        bridge_command_q[`CMD_BUS_MASTER_BIT];

    // signaled system error flag, set only by bridge messages, a new bridge message wins over the clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            system_error_signaled_flag_q <= 1'b0;
        end else if (bridge_sent) begin
            system_error_signaled_flag_q <= 1'b1;
        end else if (sts_clear_sse) begin
            system_error_signaled_flag_q <= 1'b0;
        end
    end

    // status word: hardwired ones plus the sticky flag
    always_comb begin
        bridge_status = `STS_HARDWIRED_ONES;
        bridge_status[`STS_SERR_SIGNALED_BIT] =
            system_error_signaled_flag_q;
    end

    // read data mux, unmapped offsets read zero
    always_comb begin
        read_value = 32'h0000_0000;
        if (hit_id) begin
            read_value = {PART_CODE, MAKER_CODE};
        end else if (hit_cmd_sts) begin
            // bits 9, 7, 6, 4, 3 and reserved bits come back zero
            read_value = {bridge_status,
                bridge_command_q[15:3], bus_master_enable,
                bridge_command_q[1:0]};
        end
    end

    // every cycle is answered one clock later
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_ack_q <= 1'b0;
        end else begin
            cfg_ack_q <= cfg_valid;
        end
    end

    // read data register, writes to the id dword are dropped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_rdata_q <= 32'h0000_0000;
        end else if (cfg_valid && !cfg_req.write) begin
            cfg_rdata_q <= read_value;
        end else if (cfg_valid) begin
            cfg_rdata_q <= 32'h0000_0000;
        end
    end

    // window decode under the space enables
    window_decoder u_window_decoder (
        .ref_clk(ref_clk),
        .rst(rst),
        .access_valid(access_valid),
        .access(access),
        .memory_space_enable(memory_space_enable),
        .io_space_enable(io_space_enable),
        .memory_window_base(memory_window_base),
        .memory_window_limit(memory_window_limit),
        .prefetch_window_base(prefetch_window_base),
        .prefetch_window_limit(prefetch_window_limit),
        .io_window_base(io_window_base),
        .io_window_limit(io_window_limit),
        .mem_claim_q(mem_claim_q),
        .io_claim_q(io_claim_q)
    );

    // error events become hub link messages, no error pin exists
    error_message_gate u_error_message_gate (
        .ref_clk(ref_clk),
        .rst(rst),
        .bridge_error_events(bridge_error_events),
        .bridge_control_error_enables(bridge_control_error_enables),
        .system_error_message_enable(system_error_message_enable),
        .host_error_event(host_error_event),
        .host_system_error_enable(host_system_error_enable),
        .msg_valid_q(serr_msg_valid_q),
        .msg_q(serr_msg_q),
        .msg_ready(serr_msg_ready),
        .bridge_sent_q(bridge_sent)
    );

endmodule // bridge_config_id_and_command
`default_nettype wire

// file: include/bridge_cfg_defines.svh
// offsets, field positions and reset values of the bridge config block
`ifndef BRIDGE_CFG_DEFINES_SVH
`define BRIDGE_CFG_DEFINES_SVH

// dword offsets of the configuration header slice
`define CFG_OFF_ID 8'h00
`define CFG_OFF_CMD_STS 8'h04
`define CFG_OFF_DWORD_MASK 8'hFC

// command register fields
`define CMD_IO_SPACE_BIT 0
`define CMD_MEMORY_SPACE_BIT 1
`define CMD_BUS_MASTER_BIT 2
`define CMD_SERR_ENABLE_BIT 8
`define CMD_WRITABLE_MASK 16'h0107
`define CMD_RESET_VALUE 16'h0000

// status register fields
`define STS_SERR_SIGNALED_BIT 14
`define STS_HARDWIRED_ONES 16'h00A0
`define STS_RESET_VALUE 16'h00A0

// window field positions
`define MEM_WINDOW_MSB 15
`define MEM_WINDOW_LSB 4
`define IO_WINDOW_MSB 7
`define IO_WINDOW_LSB 4

// number of bridge error conditions routed to the message gate
`define BRIDGE_ERROR_COUNT 4

`endif

// file: include/bridge_cfg_pkg.sv
// types shared by the bridge configuration block
package bridge_cfg_pkg;

    // one configuration cycle from the host
    typedef struct packed {
        logic write;
        logic [7:0] offset;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } cfg_req_t;

    // one downstream access to be claimed or not
    typedef struct packed {
        logic is_io;
        logic [31:0] addr;
    } access_t;

    // one system-error message to the upstream hub link
    typedef struct packed {
        logic from_bridge;
        logic [1:0] cause;
    } serr_msg_t;

    typedef enum logic [1:0] {
        MSG_IDLE,
        MSG_BRIDGE,
        MSG_HOST
    } msg_state_t;

endpackage

// file: logic/window_decoder.sv
// claims memory and i/o accesses falling into the bridge windows
`timescale 1ns/1ps
`default_nettype none
`include "bridge_cfg_defines.svh"

module window_decoder (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic access_valid,
    input wire bridge_cfg_pkg::access_t access,
    input wire logic memory_space_enable,
    input wire logic io_space_enable,
    input wire logic [15:0] memory_window_base,
    input wire logic [15:0] memory_window_limit,
    input wire logic [15:0] prefetch_window_base,
    input wire logic [15:0] prefetch_window_limit,
    input wire logic [7:0] io_window_base,
    input wire logic [7:0] io_window_limit,
    output logic mem_claim_q,
    output logic io_claim_q
);

    logic [11:0] mem_tag;
    logic [3:0] io_tag;
    logic in_mem;
    logic in_prefetch;
    logic in_io;

    // compare the upper address bits with each window
    assign mem_tag = access.addr[31:20];
    assign io_tag = access.addr[15:12];
    assign in_mem = (mem_tag >= memory_window_base[15:4])
        && (mem_tag <= memory_window_limit[15:4]);
    assign in_prefetch = (mem_tag >= prefetch_window_base[15:4])
        && (mem_tag <= prefetch_window_limit[15:4]);
    assign in_io = (io_tag >= io_window_base[7:4])
        && (io_tag <= io_window_limit[7:4])
        && (access.addr[31:16] == 16'h0000);

    // memory claim, both windows off when memory space is off
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_claim_q <= 1'b0;
        end else begin
            mem_claim_q <= access_valid && !access.is_io
                && memory_space_enable
                && (in_mem || in_prefetch);
        end
    end

    // i/o claim, nothing claimed when i/o space is off
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            io_claim_q <= 1'b0;
        end else begin
            io_claim_q <= access_valid && access.is_io
                && io_space_enable && in_io;
        end
    end

endmodule // window_decoder
`default_nettype wire

// file: logic/error_message_gate.sv
// turns enabled error events into system-error messages
`timescale 1ns/1ps
`default_nettype none
`include "bridge_cfg_defines.svh"

module error_message_gate (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] bridge_error_events,
    input wire logic [3:0] bridge_control_error_enables,
    input wire logic system_error_message_enable,
    input wire logic host_error_event,
    input wire logic host_system_error_enable,
    output logic msg_valid_q,
    output bridge_cfg_pkg::serr_msg_t msg_q,
    input wire logic msg_ready,
    output logic bridge_sent_q
);

    logic [3:0] pending_q;
    logic [3:0] take;
    logic host_pending_q;
    logic launch_bridge;
    logic launch_host;
    logic [1:0] pick;

    // lowest pending condition goes first
    always_comb begin
        pick = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (pending_q[i]) begin
                pick = i[1:0];
            end
        end
    end

    // nothing launches once its own enable is low, even if still pending
    assign launch_bridge = (!msg_valid_q || msg_ready)
        && system_error_message_enable && |pending_q;
    assign launch_host = (!msg_valid_q || msg_ready) && !launch_bridge
        && host_system_error_enable && host_pending_q;

    // one pending bit per bridge condition, set wins over the take clear, a low enable clears over set
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_cond
            assign take[g] = launch_bridge && (pick == g);
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    pending_q[g] <= 1'b0;
                end else if (!system_error_message_enable) begin
                    pending_q[g] <= 1'b0;
                end else if (bridge_error_events[g]
                    && bridge_control_error_enables[g]) begin
                    pending_q[g] <= 1'b1;
                end else if (take[g]) begin
                    pending_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // host-bridge errors use their own enable only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            host_pending_q <= 1'b0;
        end else if (!host_system_error_enable) begin
            host_pending_q <= 1'b0;
        end else if (host_error_event) begin
            host_pending_q <= 1'b1;
        end else if (launch_host) begin
            host_pending_q <= 1'b0;
        end
    end

    // message register held until the hub link takes it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_valid_q <= 1'b0;
            msg_q <= '0;
            bridge_sent_q <= 1'b0;
        end else begin
            bridge_sent_q <= launch_bridge;
            if (launch_bridge) begin
                msg_valid_q <= 1'b1;
                msg_q <= '{from_bridge: 1'b1, cause: pick};
            end else if (launch_host) begin
                msg_valid_q <= 1'b1;
                msg_q <= '{from_bridge: 1'b0, cause: 2'h0};
            end else if (msg_ready) begin
                msg_valid_q <= 1'b0;
            end
        end
    end

endmodule // error_message_gate
`default_nettype wire

// file: verif/bridge_config_id_and_command_chk.sv
// assertion checker for the bridge identification and command block
`timescale 1ns/1ps
`default_nettype none

module bridge_config_id_and_command_chk #(
    parameter logic [15:0] MAKER_CODE = 16'h1A2B,
    parameter logic [15:0] PART_CODE = 16'h3C4D
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cfg_valid,
    input wire bridge_cfg_pkg::cfg_req_t cfg_req,
    input wire logic cfg_ack_q,
    input wire logic [31:0] cfg_rdata_q,
    input wire logic access_valid,
    input wire bridge_cfg_pkg::access_t access,
    input wire logic mem_claim_q,
    input wire logic io_claim_q,
    input wire logic host_system_error_enable,
    input wire logic serr_msg_valid_q,
    input wire bridge_cfg_pkg::serr_msg_t serr_msg_q,
    input wire logic serr_msg_ready
);
    logic [15:0] cmd_q;
    logic rd_id;
    logic rd_cmd;
    logic wr_cmd;

    // decode of the config cycle being taken
    assign rd_id = cfg_valid && !cfg_req.write && cfg_req.offset[7:2] == 6'h00;
    assign rd_cmd = cfg_valid && !cfg_req.write
        && cfg_req.offset[7:2] == 6'h01;
    assign wr_cmd = cfg_valid && cfg_req.write && cfg_req.offset[7:2] == 6'h01;

    // shadow of the writable command bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_q <= 16'h0000;
        end else if (wr_cmd) begin
            if (cfg_req.byte_en[0]) cmd_q[7:0] <= cfg_req.wdata[7:0] & 8'h07;
            if (cfg_req.byte_en[1]) cmd_q[8] <= cfg_req.wdata[8];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_maker_code_read: assert property (
        rd_id |=> cfg_rdata_q[15:0] == MAKER_CODE)
        else $error("maker code read wrong");
    a_part_code_read: assert property (
        rd_id |=> cfg_ack_q && cfg_rdata_q[31:16] == PART_CODE)
        else $error("part code read wrong");
    a_cmd_read_back: assert property (
        rd_cmd |=> cfg_rdata_q[15:0] == $past(cmd_q))
        else $error("command read back wrong");
    a_cmd_reserved_zero: assert property (
        rd_cmd |=> cfg_rdata_q[15:9] == 7'h00 && !cfg_rdata_q[5])
        else $error("reserved command bit set");
    a_cmd_hardwired_zero: assert property (
        rd_cmd |=> {cfg_rdata_q[7:6], cfg_rdata_q[4:3]} == 4'h0)
        else $error("hardwired command bit set");
    a_mem_claim_gated: assert property (
        mem_claim_q |-> $past(access_valid) && !$past(access.is_io)
            && $past(cmd_q[1]))
        else $error("memory claim without cause");
    a_io_claim_gated: assert property (
        io_claim_q |-> $past(access_valid) && $past(access.is_io)
            && $past(cmd_q[0]) && $past(access.addr[31:16]) == 16'h0000)
        else $error("io claim without cause");
    a_bridge_msg_gated: assert property (
        $rose(serr_msg_valid_q) && serr_msg_q.from_bridge |-> $past(cmd_q[8]))
        else $error("bridge message while disabled");
    a_host_msg_gated: assert property (
        $rose(serr_msg_valid_q) && !serr_msg_q.from_bridge
            |-> $past(host_system_error_enable))
        else $error("host message while disabled");
    a_msg_held_stall: assert property (
        serr_msg_valid_q && !serr_msg_ready
            |=> serr_msg_valid_q && $stable(serr_msg_q))
        else $error("message dropped before accept");

    c_cmd_write: cover property (wr_cmd);
    c_mem_claim: cover property (mem_claim_q);
    c_bridge_msg: cover property ($rose(serr_msg_valid_q));
endmodule // bridge_config_id_and_command_chk

bind bridge_config_id_and_command bridge_config_id_and_command_chk #(
    .MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) chk_i (
    .ref_clk(ref_clk), .rst(rst), .cfg_valid(cfg_valid),
    .cfg_req(cfg_req), .cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q),
    .access_valid(access_valid), .access(access),
    .mem_claim_q(mem_claim_q), .io_claim_q(io_claim_q),
    .host_system_error_enable(host_system_error_enable),
    .serr_msg_valid_q(serr_msg_valid_q), .serr_msg_q(serr_msg_q),
    .serr_msg_ready(serr_msg_ready));
`default_nettype wire

// file: verif/bridge_config_id_and_command_tb_top.sv
// self-checking testbench of the bridge identification and command block
`timescale 1ns/1ps
`default_nettype none

module bridge_config_id_and_command_tb_top;
    logic ref_clk, rst, cfg_valid, cfg_ack_q, access_valid;
    logic mem_claim_q, io_claim_q, host_error_event, serr_msg_ready;
    logic host_system_error_enable, serr_msg_valid_q, sent;
    bridge_cfg_pkg::cfg_req_t cfg_req;
    bridge_cfg_pkg::access_t access;
    bridge_cfg_pkg::serr_msg_t serr_msg_q;
    logic [31:0] cfg_rdata_q, rdv, wd;
    logic [15:0] mwb, mwl, pwb, pwl, cmd;
    logic [7:0] iwb, iwl;
    logic [3:0] ev, en, be;
    int err_count = 0, checked = 0, n, p, i;

    bridge_config_id_and_command bridge_config_id_and_command_i (
        .ref_clk(ref_clk), .rst(rst), .cfg_valid(cfg_valid),
        .cfg_req(cfg_req), .cfg_ack_q(cfg_ack_q), .cfg_rdata_q(cfg_rdata_q),
        .access_valid(access_valid), .access(access),
        .mem_claim_q(mem_claim_q), .io_claim_q(io_claim_q),
        .memory_window_base(mwb), .memory_window_limit(mwl),
        .prefetch_window_base(pwb), .prefetch_window_limit(pwl),
        .io_window_base(iwb), .io_window_limit(iwl),
        .bridge_error_events(ev), .bridge_control_error_enables(en),
        .host_error_event(host_error_event),
        .host_system_error_enable(host_system_error_enable),
        .serr_msg_valid_q(serr_msg_valid_q), .serr_msg_q(serr_msg_q),
        .serr_msg_ready(serr_msg_ready));

    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        checked++;
        if (seen !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task tally_and_finish;
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // expected command after a write
    function logic [15:0] cmd_next(logic [15:0] c, logic [3:0] b,
                                   logic [31:0] w);
        if (b[0]) c[7:0] = w[7:0] & 8'h07;
        if (b[1]) c[15:8] = w[15:8] & 8'h01;
        return c;
    endfunction

    function logic inwin(logic [11:0] v, logic [11:0] lo, logic [11:0] hi);
        return v >= lo && v <= hi;
    endfunction

    task cfg(input logic w, input logic [7:0] o, input logic [3:0] b,
             input logic [31:0] d);
        @(posedge ref_clk) #1;
        cfg_valid = 1'h1;
        cfg_req = '{write: w, offset: o, byte_en: b, wdata: d};
        @(posedge ref_clk) #1;
        cfg_valid = 1'h0;
        rdv = cfg_rdata_q;
        check("cfg_ack", cfg_ack_q, 1'h1);
    endtask

    task rd_chk(input string nm, input logic [7:0] o, input logic [31:0] e);
        cfg(1'h0, o, 4'hF, 32'h0);
        check(nm, rdv, e);
    endtask

    task acc(input logic io, input logic [31:0] a);
        logic m, k;
        m = !io && cmd[1] && (inwin(a[31:20], mwb[15:4], mwl[15:4])
            || inwin(a[31:20], pwb[15:4], pwl[15:4]));
        k = io && cmd[0] && a[31:16] == 16'h0000
            && inwin({8'h00, a[15:12]}, {8'h00, iwb[7:4]}, {8'h00, iwl[7:4]});
        @(posedge ref_clk) #1;
        access_valid = 1'h1;
        access = '{is_io: io, addr: a};
        @(posedge ref_clk) #1;
        access_valid = 1'h0;
        check("mem_claim", mem_claim_q, m);
        check("io_claim", io_claim_q, k);
    endtask

    task msg_try(input logic [3:0] e4, input logic h, input logic v,
                 input logic [2:0] m);
        @(posedge ref_clk) #1;
        ev = e4;
        host_error_event = h;
        @(posedge ref_clk) #1;
        ev = 4'h0;
        host_error_event = 1'h0;
        for (n = 0; n < 4 && serr_msg_valid_q !== 1'h1; n++)
            @(posedge ref_clk) #1;
        // a message that never comes ends the run
        if (v && serr_msg_valid_q !== 1'h1) begin
            check("msg_timeout", serr_msg_valid_q, 1'h1);
            tally_and_finish;
        end
        check("msg_valid", serr_msg_valid_q, v);
        if (v) begin
            check("msg_src", serr_msg_q.from_bridge, m[2]);
            if (m[2]) check("msg_cause", serr_msg_q.cause, m[1:0]);
            repeat (2) @(posedge ref_clk) #1;
            serr_msg_ready = 1'h1;
            @(posedge ref_clk) #1;
            serr_msg_ready = 1'h0;
        end
    endtask

    // main sequence
    initial begin
        void'($urandom(32'h95A543A8));
        {ref_clk, cfg_valid, access_valid, host_error_event} = 4'h0;
        {serr_msg_ready, host_system_error_enable, rst} = 3'h1;
        cfg_req = '0;
        access = '0;
        {mwb, mwl, pwb, pwl, iwb, iwl, ev, en} = '0;
        cmd = 16'h0000;
        repeat (10) @(posedge ref_clk);
        #1 rst = 1'h0;
        rd_chk("id", 8'h00, {16'h3C4D, 16'h1A2B});
        rd_chk("cmd_sts", 8'h04, 32'h00A0_0000);
        cfg(1'h1, 8'h00, 4'hF, $urandom);
        rd_chk("id_wr", 8'h01, {16'h3C4D, 16'h1A2B});
        rd_chk("unmapped", 8'h40, 32'h0);
        for (i = 0; i < 24; i++) begin
            wd = (i == 0) ? 32'hFFFF_BFFF : $urandom;
            be = (i == 0) ? 4'hF : 4'($urandom);
            cmd = cmd_next(cmd, be, wd);
            cfg(1'h1, 8'h04, be, wd);
            check("wr_rdata", rdv, 32'h0);
            rd_chk("cmd", 8'h04, {16'h00A0, cmd});
        end
        for (p = 0; p < 4; p++) begin
            mwb = {4'h1, 8'($urandom), 4'h0};
            mwl = {4'h2, 8'($urandom), 4'h0};
            pwb = {4'h5, 8'($urandom), 4'h0};
            pwl = {4'h6, 8'($urandom), 4'h0};
            iwb = {4'($urandom_range(1, 3)), 4'h0};
            iwl = {4'($urandom_range(4, 6)), 4'h0};
            wd = ($urandom & 32'h4) | 32'(p);
            cmd = cmd_next(cmd, 4'h1, wd);
            cfg(1'h1, 8'h04, 4'h1, wd);
            for (i = 0; i < 16; i++) begin
                wd = $urandom;
                case ($urandom % 5)
                    0: wd[31:20] = mwb[15:4] - 12'h001;
                    1: wd[31:20] = mwb[15:4];
                    2: wd[31:20] = mwl[15:4];
                    3: wd[31:20] = pwl[15:4] + 12'h001;
                    default: ;
                endcase
                acc(1'h0, wd);
                wd[31:16] = ($urandom % 4 == 0) ? 16'h0001 : 16'h0000;
                wd[15:12] = 4'($urandom_range(0, 7));
                acc(1'h1, wd);
            end
        end
        cmd = 16'h0100;
        cfg(1'h1, 8'h04, 4'h3, 32'h0000_0100);
        sent = 1'h0;
        for (i = 0; i < 4; i++) begin
            en = 4'($urandom) | 4'h1;
            sent = sent | en[i];
            msg_try(4'h1 << i, 1'h0, en[i], {1'h1, 2'(i)});
        end
        rd_chk("sts_set", 8'h04, {1'h0, sent, 14'h00A0, cmd});
        cfg(1'h1, 8'h04, 4'h8, 32'h4000_0000);
        rd_chk("sts_clr", 8'h04, {16'h00A0, cmd});
        cmd = 16'h0000;
        cfg(1'h1, 8'h04, 4'h3, 32'h0);
        en = 4'hF;
        msg_try(4'hF, 1'h0, 1'h0, 3'h0);
        host_system_error_enable = 1'h1;
        msg_try(4'h0, 1'h1, 1'h1, 3'h0);
        rd_chk("sts_host", 8'h04, 32'h00A0_0000);
        host_system_error_enable = 1'h0;
        msg_try(4'h0, 1'h1, 1'h0, 3'h0);
        cfg(1'h1, 8'h04, 4'h3, 32'h0000_0107);
        rst = 1'h1;
        @(posedge ref_clk) #1 rst = 1'h0;
        rd_chk("cmd_rst", 8'h04, 32'h00A0_0000);
        tally_and_finish;
    end
endmodule // bridge_config_id_and_command_tb_top
`default_nettype wire
